/* asmb_regs.vh */
// Command codes, sub-codes, field positions and reset values of the alert mask bank
`ifndef ASMB_REGS_VH
`define ASMB_REGS_VH
// Shared bus command and sub-codes selecting each mask
`define ASMB_CMD_ALERT_MASK     8'h1B
`define ASMB_SUB_CURRENT        8'h7B
`define ASMB_SUB_INPUT          8'h7C
`define ASMB_SUB_TEMPERATURE    8'h7D
`define ASMB_SUB_COMM_LOGIC     8'h7E
`define ASMB_SUB_OTHER          8'h7F
// Phase selection that opens the phased masks
`define ASMB_PHASE_ALL          8'hFF
// Block byte count used by the read process call
`define ASMB_BLOCK_COUNT        8'h01
// Idle read filler once the block is exhausted
`define ASMB_FILL_BYTE          8'hFF
// Field positions, current mask
`define ASMB_OVERCURRENT_FAULT_MASK_BIT        7
`define ASMB_OVERCURRENT_WARNING_MASK_BIT      5
`define ASMB_UNDERCURRENT_FAULT_MASK_BIT       4
// Field positions, input mask
`define ASMB_INPUT_OVERVOLTAGE_FAULT_MASK_BIT  7
`define ASMB_INPUT_OVERVOLTAGE_WARNING_MASK_BIT 6
`define ASMB_INPUT_UNDERVOLTAGE_WARNING_MASK_BIT 5
`define ASMB_LOW_INPUT_MASK_BIT                3
// Field positions, temperature mask
`define ASMB_OVERTEMP_FAULT_MASK_BIT           7
`define ASMB_OVERTEMP_WARNING_MASK_BIT         6
// Field positions, communication and logic mask
`define ASMB_INVALID_COMMAND_MASK_BIT          7
`define ASMB_INVALID_DATA_MASK_BIT             6
`define ASMB_PACKET_CHECK_FAIL_MASK_BIT        5
`define ASMB_MEMORY_FAULT_MASK_BIT             4
`define ASMB_PROCESSOR_FAULT_MASK_BIT          3
`define ASMB_OTHER_COMM_FAULT_MASK_BIT         1
// Writable bits of each mask
`define ASMB_WR_CURRENT         8'hB0
`define ASMB_WR_INPUT           8'hE8
`define ASMB_WR_TEMPERATURE     8'hC0
`define ASMB_WR_COMM_LOGIC      8'hFA
// Bits restored from nonvolatile memory
`define ASMB_NVM_CURRENT        8'hB0
`define ASMB_NVM_INPUT          8'h08
`define ASMB_NVM_TEMPERATURE    8'hC0
`define ASMB_NVM_COMM_LOGIC     8'hFA
// Reset values before the nonvolatile restore
`define ASMB_RST_CURRENT        8'h00
`define ASMB_RST_INPUT          8'h00
`define ASMB_RST_TEMPERATURE    8'h00
`define ASMB_RST_COMM_LOGIC     8'h00
// Fixed value of the other-category mask
`define ASMB_OTHER_FIXED        8'h01
`endif

/* asmb_alert_mask_bank.v */
// Alert source mask bank with its SMBus command slave and alert combiner
`timescale 1ns/1ps
`include "asmb_regs.vh"
// Overview of operation
// [RULE_01] Mask bit zero passes condition, one blocks
// [RULE_02] Sub-code 7Bh selects current mask
// [RULE_03] Current mask: bits 7,5,4 writable, NVM
// [RULE_04] Sub-code 7Ch selects input mask
// [RULE_05] Input mask: 7-5 reset zero, 3 NVM
// [RULE_06] Sub-code 7Dh selects temperature mask
// [RULE_07] Temperature mask: bits 7,6 writable, NVM
// [RULE_08] Sub-code 7Eh selects communication mask
// [RULE_09] Comm mask: 7-3 and 1 writable, NVM
// [RULE_10] Sub-code 7Fh other mask, not phased
// [RULE_11] Phased masks need all-phases selection
// [RULE_12] Write word: low code, high mask
// [RULE_13] Read: one-byte block process call
// [RULE_14] Masks never stop status bits setting
// [RULE_15] Read-only positions ignore writes
// [RULE_16] Alert is any unmasked set status
module asmb_alert_mask_bank #(
   parameter [6:0] DEV_ADDR = 7'h24
) (
   input  wire       REF_CLK,
   input  wire       RESET_N,
   input  wire       SCL_I,
   input  wire       SDA_I,
   output reg        SDA_O,
   output reg        SDA_OE,
   output reg        ALERT_OE,
   output reg        PHASE_REJECT,
   input  wire [7:0] PHASE_SEL,
   input  wire       NVM_LOAD,
   input  wire [7:0] NVM_CURRENT,
   input  wire [7:0] NVM_INPUT,
   input  wire [7:0] NVM_TEMPERATURE,
   input  wire [7:0] NVM_COMM_LOGIC,
   input  wire [7:0] STATUS_CURRENT,
   input  wire [7:0] STATUS_INPUT,
   input  wire [7:0] STATUS_TEMPERATURE,
   input  wire [7:0] STATUS_COMM_LOGIC,
   input  wire [7:0] STATUS_OTHER
);

   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RX   = 5'h02;
   localparam [4:0] ST_ACK  = 5'h04;
   localparam [4:0] ST_TX   = 5'h08;
   localparam [4:0] ST_RACK = 5'h10;

   reg [7:0] current_alert_mask_r;
   reg [7:0] input_alert_mask_r;
   reg [7:0] temperature_alert_mask_r;
   reg [7:0] comm_logic_alert_mask_r;
   reg       scl_s1_r, scl_s2_r, scl_d_r;
   reg       sda_s1_r, sda_s2_r, sda_d_r;
   reg [4:0] state_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] tx_r;
   reg [1:0] byte_idx_r;
   reg [1:0] tx_idx_r;
   reg       rd_r;
   reg       cmd_ok_r;
   reg       data_seen_r;
   reg [7:0] second_r;
   reg [7:0] code_r;
   reg       ack_nxt;

   // Codes reached only with all phases selected
   function phased;
      input [7:0] code;
      begin
         phased = (code == `ASMB_SUB_CURRENT) || (code == `ASMB_SUB_INPUT) ||
                  (code == `ASMB_SUB_TEMPERATURE) || (code == `ASMB_SUB_COMM_LOGIC);
      end
   endfunction

   // Mask readback; phased masks read zero under a single-phase selection
   function [7:0] mask_read;
      input [7:0] code;
      input [7:0] phase;
      begin
         mask_read = 8'h00;
         if (phased(code) && phase != `ASMB_PHASE_ALL) begin
            mask_read = 8'h00; // RULE_11
         end else begin
            case (code)
               `ASMB_SUB_CURRENT:     mask_read = current_alert_mask_r; // RULE_02
               `ASMB_SUB_INPUT:       mask_read = input_alert_mask_r; // RULE_04
               `ASMB_SUB_TEMPERATURE: mask_read = temperature_alert_mask_r; // RULE_06
               `ASMB_SUB_COMM_LOGIC:  mask_read = comm_logic_alert_mask_r; // RULE_08
               `ASMB_SUB_OTHER:       mask_read = `ASMB_OTHER_FIXED; // RULE_10
               default:               mask_read = 8'h00;
            endcase
         end
      end
   endfunction

   // Two-stage synchronisers plus one delay stage for edge finding
   always @(posedge REF_CLK) begin
      if (!RESET_N) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r  <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r  <= 1'b1;
      end else begin
         scl_s1_r <= SCL_I;
         scl_s2_r <= scl_s1_r;
         scl_d_r  <= scl_s2_r;
         sda_s1_r <= SDA_I;
         sda_s2_r <= sda_s1_r;
         sda_d_r  <= sda_s2_r;
      end
   end

   // Bus conditions, read only from the second stage onward
   wire scl_rise = scl_s2_r & ~scl_d_r;
   wire scl_fall = ~scl_s2_r & scl_d_r;
   wire bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   wire bus_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   // Mask write request decoded from the fourth byte of the frame (byte index 3, after address, command and code); a trailing
   // checksum byte must not land as a second mask value
   wire       byte_done = (state_r == ST_RX) && scl_fall && (bit_cnt_r == 4'h8);
   wire       mask_wr = byte_done && (byte_idx_r == 2'd3) && !data_seen_r && cmd_ok_r &&
                        (second_r != `ASMB_BLOCK_COUNT); // RULE_12
   wire       wr_open = !phased(second_r) || (PHASE_SEL == `ASMB_PHASE_ALL); // RULE_11
   wire       rd_req  = byte_done && (byte_idx_r == 2'd3) && !data_seen_r && cmd_ok_r &&
                        (second_r == `ASMB_BLOCK_COUNT); // RULE_13

   // Acknowledge decision for the byte just received
   always @* begin
      ack_nxt = 1'b1;
      if (byte_idx_r == 2'd0) begin
         ack_nxt = (shift_r[7:1] == DEV_ADDR);
      end
   end

   // Byte engine: receive, acknowledge, transmit
   always @(posedge REF_CLK) begin
      if (!RESET_N) begin
         state_r    <= ST_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         tx_r       <= 8'h00;
         byte_idx_r <= 2'd0;
         tx_idx_r   <= 2'd0;
         rd_r       <= 1'b0;
         cmd_ok_r   <= 1'b0;
         data_seen_r <= 1'b0;
         second_r   <= 8'h00;
         code_r     <= 8'h00;
         SDA_O      <= 1'b0;
         SDA_OE     <= 1'b0;
      end else if (bus_start) begin
         // Start and repeated start both restart the address phase
         state_r    <= ST_RX;
         bit_cnt_r  <= 4'h0;
         byte_idx_r <= 2'd0;
         data_seen_r <= 1'b0;
         SDA_OE     <= 1'b0;
      end else if (bus_stop) begin
         state_r  <= ST_IDLE;
         SDA_OE   <= 1'b0;
         cmd_ok_r <= 1'b0;
      end else begin
         SDA_O <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               SDA_OE <= 1'b0;
            end
            ST_RX: begin
               if (scl_rise && bit_cnt_r != 4'h8) begin
                  shift_r   <= {shift_r[6:0], sda_s2_r};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (byte_done) begin
                  if (!ack_nxt) begin
                     state_r <= ST_IDLE; // Not our address: stay off the bus
                  end else begin
                     state_r <= ST_ACK;
                     SDA_OE  <= 1'b1;
                  end
                  case (byte_idx_r)
                     2'd0: begin
                        rd_r     <= shift_r[0];
                        tx_idx_r <= 2'd0;
                     end
                     2'd1: cmd_ok_r <= (shift_r == `ASMB_CMD_ALERT_MASK);
                     2'd2: second_r <= shift_r;
                     default: begin
                        data_seen_r <= 1'b1;
                        if (rd_req) begin
                           code_r <= shift_r; // RULE_13
                        end
                     end
                  endcase
                  if (byte_idx_r != 2'd3) begin
                     byte_idx_r <= byte_idx_r + 2'd1;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt_r <= 4'h0;
                  if (rd_r) begin
                     // Count byte first, then the mask, then filler
                     state_r  <= ST_TX;
                     SDA_OE   <= (`ASMB_BLOCK_COUNT < 8'h80); // Pull for a zero lead bit
                     tx_r     <= `ASMB_BLOCK_COUNT;
                     tx_idx_r <= 2'd1;
                     bit_cnt_r <= 4'h1;
                  end else begin
                     state_r <= ST_RX;
                     SDA_OE  <= 1'b0;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_r == 4'h8) begin
                     state_r <= ST_RACK;
                     SDA_OE  <= 1'b0;
                  end else begin
                     SDA_OE    <= ~tx_r[6];
                     tx_r      <= {tx_r[6:0], 1'b1};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  rd_r <= ~sda_s2_r; // Master acknowledge keeps the read going
               end else if (scl_fall) begin
                  if (rd_r) begin
                     state_r   <= ST_TX;
                     bit_cnt_r <= 4'h1;
                     tx_idx_r  <= (tx_idx_r == 2'd3) ? 2'd3 : tx_idx_r + 2'd1;
                     if (tx_idx_r == 2'd1) begin
                        tx_r   <= mask_read(code_r, PHASE_SEL); // RULE_13
                        SDA_OE <= (mask_read(code_r, PHASE_SEL) < 8'h80);
                     end else begin
                        tx_r   <= `ASMB_FILL_BYTE;
                        SDA_OE <= 1'b0;
                     end
                  end else begin
                     state_r <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_r <= ST_IDLE;
               SDA_OE  <= 1'b0;
            end
         endcase
      end
   end

   // Mask storage: reset, nonvolatile restore, then host writes
   always @(posedge REF_CLK) begin
      if (!RESET_N) begin
         current_alert_mask_r     <= `ASMB_RST_CURRENT;
         input_alert_mask_r       <= `ASMB_RST_INPUT; // RULE_05
         temperature_alert_mask_r <= `ASMB_RST_TEMPERATURE;
         comm_logic_alert_mask_r  <= `ASMB_RST_COMM_LOGIC;
      end else if (NVM_LOAD) begin
         // Only backed bits are restored; input bits 7..5 keep their zero reset
         current_alert_mask_r <= (current_alert_mask_r & ~`ASMB_NVM_CURRENT) |
                                 (NVM_CURRENT & `ASMB_NVM_CURRENT); // RULE_03
         input_alert_mask_r <= (input_alert_mask_r & ~`ASMB_NVM_INPUT) |
                               (NVM_INPUT & `ASMB_NVM_INPUT); // RULE_05
         temperature_alert_mask_r <= (temperature_alert_mask_r & ~`ASMB_NVM_TEMPERATURE) |
                                     (NVM_TEMPERATURE & `ASMB_NVM_TEMPERATURE); // RULE_07
         comm_logic_alert_mask_r <= (comm_logic_alert_mask_r & ~`ASMB_NVM_COMM_LOGIC) |
                                    (NVM_COMM_LOGIC & `ASMB_NVM_COMM_LOGIC); // RULE_09
      end else if (mask_wr && wr_open) begin
         // Fixed positions never take written data
         case (second_r)
            `ASMB_SUB_CURRENT:
               current_alert_mask_r <= shift_r & `ASMB_WR_CURRENT; // RULE_15
            `ASMB_SUB_INPUT:
               input_alert_mask_r <= shift_r & `ASMB_WR_INPUT; // RULE_15
            `ASMB_SUB_TEMPERATURE:
               temperature_alert_mask_r <= shift_r & `ASMB_WR_TEMPERATURE; // RULE_07
            `ASMB_SUB_COMM_LOGIC:
               comm_logic_alert_mask_r <= shift_r & `ASMB_WR_COMM_LOGIC; // RULE_09
            default: ; // Other mask is fixed; unknown codes ignored
         endcase
      end
   end

   // Pulse when a phased mask is touched under a single-phase selection
   always @(posedge REF_CLK) begin
      if (!RESET_N) begin
         PHASE_REJECT <= 1'b0;
      end else begin
         PHASE_REJECT <= (mask_wr && !wr_open) ||
                         (rd_req && phased(shift_r) && PHASE_SEL != `ASMB_PHASE_ALL); // RULE_11
      end
   end

   // Alert combiner; status inputs are only read, never altered here
   always @(posedge REF_CLK) begin
      if (!RESET_N) begin
         ALERT_OE <= 1'b0;
      end else begin
         ALERT_OE <= |(STATUS_CURRENT & ~current_alert_mask_r) |
                     |(STATUS_INPUT & ~input_alert_mask_r) |
                     |(STATUS_TEMPERATURE & ~temperature_alert_mask_r) |
                     |(STATUS_COMM_LOGIC & ~comm_logic_alert_mask_r) |
                     |(STATUS_OTHER & ~`ASMB_OTHER_FIXED); // RULE_01 RULE_14 RULE_16
      end
   end

endmodule

/* asmb_monitor.sv */
// Concurrent checks on the port behaviour of the alert mask bank
`timescale 1ns/1ps
module asmb_monitor (
   input wire       REF_CLK,
   input wire       RESET_N,
   input wire       SDA_O,
   input wire       SDA_OE,
   input wire       ALERT_OE,
   input wire       PHASE_REJECT,
   input wire [7:0] PHASE_SEL,
   input wire [7:0] STATUS_CURRENT,
   input wire [7:0] STATUS_INPUT,
   input wire [7:0] STATUS_TEMPERATURE,
   input wire [7:0] STATUS_COMM_LOGIC,
   input wire [7:0] STATUS_OTHER
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   // Any status that may raise the alert; other bit 0 is hard-masked
   wire any_st = (|{STATUS_CURRENT, STATUS_INPUT, STATUS_TEMPERATURE, STATUS_COMM_LOGIC})
                 | (|STATUS_OTHER[7:1]);

   a_open_drain_low: assert property (SDA_O == 1'b0)
      else $error("data pin output value not low");
   a_reset_quiet: assert property (disable iff (1'b0)
      !RESET_N |=> !SDA_OE && !ALERT_OE && !PHASE_REJECT)
      else $error("outputs active after reset edge");
   a_alert_idle: assert property (!any_st |=> !ALERT_OE)
      else $error("alert without any status bit set");
   a_alert_cause: assert property ($rose(ALERT_OE) |-> $past(any_st))
      else $error("alert rose with no status cause");
   a_reject_pulse: assert property (PHASE_REJECT |=> !PHASE_REJECT)
      else $error("phase reject longer than one cycle");
   a_reject_phase: assert property (PHASE_REJECT |-> $past(PHASE_SEL) != 8'hFF)
      else $error("phase reject under all-phases selection");
   a_accept_all: assert property ($stable(PHASE_SEL) && PHASE_SEL == 8'hFF |->
      !PHASE_REJECT)
      else $error("reject while all phases selected");
   a_ack_holds: assert property ($rose(SDA_OE) |-> SDA_OE [*4])
      else $error("data pin pull released too early");

   // Main scenarios reached
   c_reject: cover property (PHASE_REJECT);
   c_alert: cover property ($rose(ALERT_OE));
   c_ack: cover property ($rose(SDA_OE));
endmodule

/* asmb_host_model.sv */
// SMBus host model: bit-banged master at an 80 ns bit period
`timescale 1ns/1ps
module asmb_host_model (
   input  wire REF_CLK,
   input  wire SDA_BUS,
   output reg  SCL,
   output reg  SDA
);
   // Idle bus: both lines released high, clock still between frames
   initial begin
      SCL = 1'b1;
      SDA = 1'b1;
   end
   task tk(input integer n);
      repeat (n) @(posedge REF_CLK);
   endtask
   // Data moves one cycle after the clock fall so no false start is seen
   task bitx(input logic b, output logic r);
      tk(1);
      SDA <= b;
      tk(4);
      SCL <= 1'b1;
      tk(3);
      r = SDA_BUS;
      SCL <= 1'b0;
   endtask
   // Start; from a low clock this becomes a repeated start, from idle the
   // release steps change nothing, so no test of a pending clock value
   task start;
      tk(1);
      SDA <= 1'b1;
      tk(4);
      SCL <= 1'b1;
      tk(4);
      SDA <= 1'b0;
      tk(4);
      SCL <= 1'b0;
   endtask
   task stop;
      tk(1);
      SDA <= 1'b0;
      tk(4);
      SCL <= 1'b1;
      tk(4);
      SDA <= 1'b1;
      tk(4);
   endtask
   // Eight bits MSB first, then the acknowledge bit
   task bytex(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic a);
      integer k;
      for (k = 7; k >= 0; k--) bitx(d[k], q[k]);
      bitx(ma, a);
   endtask
   // Write word: shared command, code low byte, mask high byte
   task wr(input logic [6:0] adr, input logic [7:0] code, input logic [7:0] m,
           output logic nak);
      logic [7:0] q;
      logic       a;
      start();
      bytex({adr, 1'b0}, 1'b1, q, nak);
      bytex(8'h1B, 1'b1, q, a);
      bytex(code, 1'b1, q, a);
      bytex(m, 1'b1, q, a);
      stop();
   endtask
   // Process call: one-byte block with the code, one-byte block back
   task rd(input logic [6:0] adr, input logic [7:0] code, output logic [7:0] cnt,
           output logic [7:0] q);
      logic a;
      start();
      bytex({adr, 1'b0}, 1'b1, q, a);
      bytex(8'h1B, 1'b1, q, a);
      bytex(8'h01, 1'b1, q, a);
      bytex(code, 1'b1, q, a);
      start();
      bytex({adr, 1'b1}, 1'b1, q, a);
      bytex(8'hFF, 1'b0, cnt, a);
      bytex(8'hFF, 1'b1, q, a);
      stop();
   endtask
endmodule

/* tb_alert_source_mask_bank.sv */
// Self-checking bench for the alert mask bank through its SMBus slave
`timescale 1ns/1ps
module tb_alert_source_mask_bank;
   localparam logic [6:0] ADR = 7'h24;
   localparam logic [7:0] SUB [4] = '{8'h7B, 8'h7C, 8'h7D, 8'h7E};
   localparam logic [7:0] WRM [4] = '{8'hB0, 8'hE8, 8'hC0, 8'hFA};
   localparam logic [7:0] NVB [4] = '{8'hB0, 8'h08, 8'hC0, 8'hFA};
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       nvm_load = 1'b0;
   logic [7:0] phase = 8'hFF;
   logic [7:0] nvm [4] = '{default: 8'h00};
   logic [7:0] st [5] = '{default: 8'h00};
   logic       nak;
   wire        scl, sda_h, sda_oe, alert, rej;
   wire        sda_i = sda_h & ~sda_oe;
   integer     num_errors = 0, cmp_count = 0, cyc = 0, n_rej = 0, i;

   always #5 clk = ~clk;
   asmb_alert_mask_bank #(.DEV_ADDR(ADR)) dut (
      .REF_CLK(clk), .RESET_N(rst_n), .SCL_I(scl), .SDA_I(sda_i), .SDA_O(),
      .SDA_OE(sda_oe), .ALERT_OE(alert), .PHASE_REJECT(rej), .PHASE_SEL(phase),
      .NVM_LOAD(nvm_load), .NVM_CURRENT(nvm[0]), .NVM_INPUT(nvm[1]),
      .NVM_TEMPERATURE(nvm[2]), .NVM_COMM_LOGIC(nvm[3]), .STATUS_CURRENT(st[0]),
      .STATUS_INPUT(st[1]), .STATUS_TEMPERATURE(st[2]), .STATUS_COMM_LOGIC(st[3]),
      .STATUS_OTHER(st[4]));
   asmb_host_model host (.REF_CLK(clk), .SDA_BUS(sda_i), .SCL(scl), .SDA(sda_h));

   // Reject pulses counted; a hang is cut short by the cycle ceiling
   always @(posedge clk) begin
      if (rej === 1'b1) n_rej <= n_rej + 1;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         print_verdict();
      end
   end
   task print_verdict;
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tk(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task wrc(input logic [7:0] code, input logic [7:0] m);
      host.wr(ADR, code, m, nak);
      chk("address ack", {7'h00, nak}, 8'h00);
   endtask
   // Read a mask; the block count is checked on every read
   task rdc(input logic [7:0] code, input logic [7:0] exp);
      logic [7:0] c, q;
      host.rd(ADR, code, c, q);
      chk("block count", c, 8'h01);
      chk("mask read", q, exp);
   endtask

   initial begin
      tk(5);
      rst_n <= 1'b1;
      tk(3);
      // Masks clear out of reset, other mask fixed
      for (i = 0; i < 4; i++) rdc(SUB[i], 8'h00);
      rdc(8'h7F, 8'h01);
      $display("test reset done");
      // Restore from all-ones store: only backed bits follow it
      for (i = 0; i < 4; i++) nvm[i] <= 8'hFF;
      nvm_load <= 1'b1;
      tk(1);
      nvm_load <= 1'b0;
      for (i = 0; i < 4; i++) rdc(SUB[i], NVB[i]);
      $display("test restore done");
      // Read-only positions ignore written ones
      for (i = 0; i < 4; i++) begin
         wrc(SUB[i], 8'hFF);
         rdc(SUB[i], WRM[i]);
         wrc(SUB[i], 8'h00);
         rdc(SUB[i], 8'h00);
      end
      wrc(8'h7F, 8'hFE);
      rdc(8'h7F, 8'h01);
      $display("test access done");
      // Single phase selected: phased masks refused, other mask still open
      wrc(8'h7D, 8'hC0);
      phase <= 8'h00;
      wrc(8'h7D, 8'h00);
      rdc(8'h7D, 8'h00);
      rdc(8'h7F, 8'h01);
      phase <= 8'hFF;
      rdc(8'h7D, 8'hC0);
      wrc(8'h7D, 8'h00);
      chk("reject pulses", n_rej[7:0], 8'h02);
      $display("test phase done");
      // Each phased category raises the alert until its mask blocks it
      for (i = 0; i < 4; i++) begin
         st[i] <= WRM[i];
         tk(3);
         chk("alert unmasked", {7'h00, alert}, 8'h01);
         wrc(SUB[i], 8'hFF);
         tk(3);
         chk("alert masked", {7'h00, alert}, 8'h00);
         wrc(SUB[i], 8'h00);
         st[i] <= 8'h00;
      end
      st[4] <= 8'h01;
      tk(3);
      chk("alert other", {7'h00, alert}, 8'h00);
      // Upper other-category bits are not masked and must raise the alert
      st[4] <= 8'h02;
      tk(3);
      chk("alert other set", {7'h00, alert}, 8'h01);
      st[4] <= 8'h00;
      $display("test alert done");
      // Foreign address is not acknowledged and changes nothing
      host.wr(ADR ^ 7'h01, 8'h7D, 8'hC0, nak);
      chk("foreign nack", {7'h00, nak}, 8'h01);
      rdc(8'h7D, 8'h00);
      $display("test address done");
      print_verdict();
   end
endmodule

bind asmb_alert_mask_bank asmb_monitor mon (
   .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
   .ALERT_OE(ALERT_OE), .PHASE_REJECT(PHASE_REJECT), .PHASE_SEL(PHASE_SEL),
   .STATUS_CURRENT(STATUS_CURRENT), .STATUS_INPUT(STATUS_INPUT),
   .STATUS_TEMPERATURE(STATUS_TEMPERATURE), .STATUS_COMM_LOGIC(STATUS_COMM_LOGIC),
   .STATUS_OTHER(STATUS_OTHER));
